// ### hw/ipr_hazard_map.svh
`ifndef IPR_HAZARD_MAP_SVH
`define IPR_HAZARD_MAP_SVH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_EXCEPTION_ADDRESS_REG_LO 8'h08
`define OFS_EXCEPTION_ADDRESS_REG_HI 8'h0C
`define OFS_EXCEPTION_SUMMARY_REG 8'h10
`define OFS_IVA_FMT_LO 8'h14
`define OFS_IVA_FMT_HI 8'h18
`define OFS_FAULT_VA_LO 8'h1C
`define OFS_FAULT_VA_HI 8'h20
`define OFS_DVA_FMT_LO 8'h24
`define OFS_DVA_FMT_HI 8'h28
`define OFS_MEMORY_MGMT_STATUS_REG 8'h2C
`define OFS_DTLB_BASE 8'h30
`define OFS_DTLB_LAST 8'h3C
// control field positions and reset value
`define CTRL_IVA48 0
`define CTRL_DVA48 1
`define CTRL_IFMT32 2
`define CTRL_DFMT32 3
`define CTRL_RESET 4'h0
// status field positions
`define STAT_LOCKED 0
`define STAT_MARK 1
`define STAT_POS 2
`define STAT_PEND 4
`define STAT_STAGED 5
// sign-extension masks: bits that must all match
`define MASK_VA43 64'hFFFF_FC00_0000_0000
`define MASK_VA48 64'hFFFF_8000_0000_0000
// double-miss firmware entry offsets, arbitrary values
`define DBL3_ENTRY 16'h0100
`define DBL4_ENTRY 16'h0180
// timing counts: read-to-write spacing in cycles, lock window in retired instructions
`define RMW_MIN_CYC 5'd4
`define RMW_MAX_CYC 5'd9
`define LOCK_INSTR 3'd4
`endif

// ### hw/ipr_hazard_pkg.sv
package ipr_hazard_pkg;
  // trap reported by the exception logic
  typedef struct packed {
    logic valid;
    logic [63:0] pc;
    logic fw_mode;
    logic bad_istream_va_flag;
    logic jump;
    logic [31:0] summary;
  } trap_t;
  // data-stream fault reported by the memory unit
  typedef struct packed {
    logic valid;
    logic [63:0] va;
    logic [31:0] stat;
  } dfault_t;
  // one integer-queue enqueue
  typedef struct packed {
    logic valid;
    logic [1:0] pos;
  } enq_t;
  typedef enum logic {
    LK_OPEN = 1'b0,
    LK_HELD = 1'b1
  } lock_state_t;
endpackage : ipr_hazard_pkg

// ### hw/trap_lock_unit.sv
`timescale 1ns/10ps
`include "ipr_hazard_map.svh"
module trap_lock_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events
  input wire logic trap_valid,
  input wire logic retire_valid,
  input wire logic retire_taken_branch,
  // results
  output logic accept,
  output logic trap_to_fw,
  output logic trap_replay,
  output logic locked
);
  import ipr_hazard_pkg::*;
  lock_state_t state;
  logic [2:0] retired;
  wire logic delimiter;

  // fourth instruction or first taken branch ends the window
  assign delimiter = retire_valid & (retire_taken_branch | (retired == (`LOCK_INSTR - 3'd1)));
  // only an unlocked trap may load the registers
  assign accept = trap_valid & (state == LK_OPEN);

  // lock state; a trap in the unlocking cycle is still replayed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= LK_OPEN;
      retired <= 3'h0;
      trap_to_fw <= 1'b0;
      trap_replay <= 1'b0;
      locked <= 1'b0;
    end else begin
      trap_to_fw <= accept;
      trap_replay <= trap_valid & (state == LK_HELD);
      locked <= accept | (locked & ~delimiter);
      unique case (state)
        LK_OPEN: begin
          if (accept) begin
            state <= LK_HELD;
            retired <= 3'h0;
          end
        end
        LK_HELD: begin
          if (delimiter) begin
            state <= LK_OPEN;
          end else if (retire_valid) begin
            retired <= retired + 3'd1;
          end
        end
      endcase
    end
  end
endmodule : trap_lock_unit

// ### hw/replay_mark_unit.sv
`timescale 1ns/10ps
module replay_mark_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // replay trap from the memory unit
  input wire logic replay_trap,
  input wire logic [1:0] replay_pc_lo,
  input wire logic replay_is_mem,
  // integer-queue enqueue
  input wire ipr_hazard_pkg::enq_t enq,
  // results
  output logic mark_valid,
  output logic [1:0] mark_pos,
  output logic skip_dirty,
  output logic head_issue
);
  import ipr_hazard_pkg::*;
  wire logic hit;

  // next valid enqueue at the marked slot consumes the mark
  assign hit = enq.valid & mark_valid & (enq.pos == mark_pos);

  // a new replay in the consuming cycle keeps its mark
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mark_valid <= 1'b0;
      mark_pos <= 2'h0;
      skip_dirty <= 1'b0;
      head_issue <= 1'b0;
    end else begin
      skip_dirty <= hit; // source taken as clean
      head_issue <= replay_trap & replay_is_mem; // ahead of younger memory ops
      if (replay_trap) begin
        mark_valid <= 1'b1;
        mark_pos <= replay_pc_lo;
      end else if (hit) begin
        mark_valid <= 1'b0;
      end
    end
  end
endmodule : replay_mark_unit

// ### hw/ipr_hazard_ctrl.sv
// Functional notes
// - read to dependent write issue spacing is four to nine cycles.
// - replayed memory op issues ahead of younger ones, no dirty dependencies.
// - replayed floating-point store skips its source dirty check.
// - replay slot is low two PC bits; next enqueue there cancels check.
// - istream width bit picks entry, compare width, VPC, fetch limits, format.
// - dstream width bit picks data format layout and data limits.
// - new control value takes effect only when its write retires.
// - trap locks address, format and summary and delays later traps.
// - lock lasts four instructions or to first taken branch retire.
// - exception while locked becomes a replay; after unlock it traps.
// - fault address, data format and status stay writable after traps.
// - bad jump address goes to fault VA, firmware bit stays bit 0.
// - four data-TLB tag and entry writes take effect all or none.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
`include "ipr_hazard_map.svh"
module ipr_hazard_ctrl #(
  parameter int ADDR_W = 8,
  parameter int DEPTH_W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trap, retire and fault events
  input wire ipr_hazard_pkg::trap_t trap,
  input wire ipr_hazard_pkg::dfault_t dfault,
  input wire logic retire_valid,
  input wire logic retire_taken_branch,
  input wire logic ipr_write_retire,
  // replay and enqueue
  input wire logic replay_trap,
  input wire logic [1:0] replay_pc_lo,
  input wire logic replay_is_mem,
  input wire ipr_hazard_pkg::enq_t enq,
  // read-modify-write pacing
  input wire logic ipr_read_issue,
  input wire logic ipr_write_issue,
  input wire logic [DEPTH_W-1:0] queue_depth,
  // address checks
  input wire logic fetch_valid,
  input wire logic [63:0] fetch_va,
  input wire logic data_valid,
  input wire logic [63:0] data_va,
  input wire logic dtlb_flush,
  // trap results
  output logic trap_to_fw,
  output logic trap_replay,
  output logic locked,
  output logic skip_dirty,
  output logic head_issue,
  output logic rmw_write_ok,
  // mode outputs
  output logic istream_va48,
  output logic dstream_va48,
  output logic istream_fmt32,
  output logic dstream_fmt32,
  output logic [15:0] dbl_miss_entry,
  output logic istream_access_violation,
  output logic dstream_access_violation,
  // data-TLB update, all four words at once
  output logic dtlb_commit,
  output logic [3:0][31:0] dtlb_word
);
  import ipr_hazard_pkg::*;

  // true when every bit above the mode's top bit copies it
  function automatic logic sign_ok(input logic [63:0] va, input logic w48);
    logic [63:0] m;
    m = w48 ? `MASK_VA48 : `MASK_VA43;
    sign_ok = ((va & m) == 64'h0) | ((va & m) == m);
  endfunction : sign_ok

  // page-table style format; layout follows width and 32-bit selects
  function automatic logic [63:0] va_format(input logic [63:0] va, input logic w48, input logic f32);
    logic [63:0] r;
    r = {31'h0, va[42:13], 3'h0};
    if (f32) begin
      r = {41'h0, va[32:13], 3'h0};
    end else if (w48) begin
      r = {26'h0, va[47:13], 3'h0};
    end
    va_format = r;
  endfunction : va_format

  // wait target grows with queue contents, never below min nor above max
  function automatic logic [4:0] rmw_target(input logic [DEPTH_W-1:0] depth);
    logic [5:0] s;
    s = {1'b0, `RMW_MIN_CYC} + 6'(depth);
    rmw_target = (s > {1'b0, `RMW_MAX_CYC}) ? `RMW_MAX_CYC : s[4:0];
  endfunction : rmw_target

  // register state
  logic [3:0] ctrl;
  logic [3:0] ctrl_pending;
  logic pend;
  logic [63:0] exception_address_reg;
  logic [31:0] exception_summary_reg;
  logic [63:0] iva_fmt;
  logic [63:0] fault_va;
  logic [63:0] dva_fmt;
  logic [31:0] memory_mgmt_status_reg;
  logic [31:0] stage [4];
  logic [3:0] staged;
  logic rmw_busy;
  logic [4:0] rmw_cnt;
  logic [4:0] rmw_goal;
  logic [31:0] rd_word;

  // sub-unit results
  wire logic accept;
  wire logic mark_valid;
  wire logic [1:0] mark_pos;

  // apb phases: one wait state, then answer
  wire logic access;
  wire logic first;
  wire logic done;
  wire logic wr;
  assign access = psel & penable;
  assign first = access & ~pready;
  assign done = access & pready;
  assign wr = done & pwrite;

  // address decode
  wire logic [ADDR_W-1:0] a;
  wire logic sel_ctrl;
  wire logic sel_dtlb;
  wire logic mapped;
  wire logic [1:0] dtlb_idx;
  assign a = paddr;
  assign sel_ctrl = (a == ADDR_W'(`OFS_CTRL));
  assign sel_dtlb = (a >= ADDR_W'(`OFS_DTLB_BASE)) & (a <= ADDR_W'(`OFS_DTLB_LAST)) & (a[1:0] == 2'h0);
  assign dtlb_idx = a[3:2];
  assign mapped = (a[1:0] == 2'h0) & (a <= ADDR_W'(`OFS_DTLB_LAST));

  // bad jump target moves to the fault address register
  wire logic bad_jump;
  wire logic [63:0] next_fault_va;
  wire logic load_fault;
  assign bad_jump = accept & trap.bad_istream_va_flag & trap.jump;
  assign next_fault_va = bad_jump ? {trap.pc[63:1], 1'b0} : dfault.va;
  assign load_fault = bad_jump | dfault.valid;

  // dtlb group is complete once all four words are staged
  wire logic [3:0] staged_set;
  wire logic dtlb_full;
  assign staged_set = (wr & sel_dtlb) ? (4'h1 << dtlb_idx) : 4'h0;
  assign dtlb_full = (staged == 4'hF);

  // read multiplexer; unmapped reads return zero
  always_comb begin
    rd_word = 32'h0;
    unique case (a)
      ADDR_W'(`OFS_CTRL): rd_word = {28'h0, ctrl};
      ADDR_W'(`OFS_STATUS): rd_word = {23'h0, staged, pend, mark_pos, mark_valid, locked};
      ADDR_W'(`OFS_EXCEPTION_ADDRESS_REG_LO): rd_word = exception_address_reg[31:0];
      ADDR_W'(`OFS_EXCEPTION_ADDRESS_REG_HI): rd_word = exception_address_reg[63:32];
      ADDR_W'(`OFS_EXCEPTION_SUMMARY_REG): rd_word = exception_summary_reg;
      ADDR_W'(`OFS_IVA_FMT_LO): rd_word = iva_fmt[31:0];
      ADDR_W'(`OFS_IVA_FMT_HI): rd_word = iva_fmt[63:32];
      ADDR_W'(`OFS_FAULT_VA_LO): rd_word = fault_va[31:0];
      ADDR_W'(`OFS_FAULT_VA_HI): rd_word = fault_va[63:32];
      ADDR_W'(`OFS_DVA_FMT_LO): rd_word = dva_fmt[31:0];
      ADDR_W'(`OFS_DVA_FMT_HI): rd_word = dva_fmt[63:32];
      ADDR_W'(`OFS_MEMORY_MGMT_STATUS_REG): rd_word = memory_mgmt_status_reg;
      default: rd_word = sel_dtlb ? stage[dtlb_idx] : 32'h0;
    endcase
  end

  // bus answer registered in the wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= first;
      prdata <= (first & ~pwrite) ? rd_word : 32'h0;
      pslverr <= first & ~mapped;
    end
  end

  // staged control becomes active on write retirement
  // a new write in the retiring cycle stays pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      ctrl_pending <= `CTRL_RESET;
      pend <= 1'b0;
    end else begin
      if (ipr_write_retire & pend) begin
        ctrl <= ctrl_pending;
      end
      if (wr & sel_ctrl) begin
        ctrl_pending <= pwdata[3:0];
        pend <= 1'b1;
      end else if (ipr_write_retire) begin
        pend <= 1'b0;
      end
    end
  end

  // mode bits steer fetch and data paths
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istream_va48 <= 1'b0;
      dstream_va48 <= 1'b0;
      istream_fmt32 <= 1'b0;
      dstream_fmt32 <= 1'b0;
      dbl_miss_entry <= `DBL3_ENTRY;
      istream_access_violation <= 1'b0;
      dstream_access_violation <= 1'b0;
    end else begin
      istream_va48 <= ctrl[`CTRL_IVA48]; // jump compare and vpc width
      dstream_va48 <= ctrl[`CTRL_DVA48];
      istream_fmt32 <= ctrl[`CTRL_IFMT32];
      dstream_fmt32 <= ctrl[`CTRL_DFMT32];
      dbl_miss_entry <= ctrl[`CTRL_IVA48] ? `DBL4_ENTRY : `DBL3_ENTRY;
      // fetch and data addresses must sign-extend for their mode
      istream_access_violation <= fetch_valid & ~sign_ok(fetch_va, ctrl[`CTRL_IVA48]);
      dstream_access_violation <= data_valid & ~sign_ok(data_va, ctrl[`CTRL_DVA48]);
    end
  end

  // trap-locked registers load only on an accepted trap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exception_address_reg <= 64'h0;
      exception_summary_reg <= 32'h0;
      iva_fmt <= 64'h0;
    end else if (accept) begin
      exception_address_reg <= bad_jump ? {63'h0, trap.fw_mode} : {trap.pc[63:1], trap.fw_mode};
      exception_summary_reg <= trap.summary;
      iva_fmt <= va_format(trap.pc, ctrl[`CTRL_IVA48], ctrl[`CTRL_IFMT32]);
    end
  end

  // unlocked registers follow every data fault, even while locked, unless a bad jump in the same cycle takes address and format
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_va <= 64'h0;
      dva_fmt <= 64'h0;
      memory_mgmt_status_reg <= 32'h0;
    end else begin
      if (load_fault) begin
        fault_va <= next_fault_va;
        dva_fmt <= va_format(next_fault_va, ctrl[`CTRL_DVA48], ctrl[`CTRL_DFMT32]);
      end
      if (dfault.valid) begin
        memory_mgmt_status_reg <= dfault.stat;
      end
    end
  end

  // dtlb staging: commit all four together or drop all on flush
  // a write in the flush cycle survives the flush
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      staged <= 4'h0;
      dtlb_commit <= 1'b0;
      dtlb_word <= '0;
      for (int i = 0; i < 4; i++) begin
        stage[i] <= 32'h0;
      end
    end else begin
      dtlb_commit <= dtlb_full & ~dtlb_flush;
      if (wr & sel_dtlb) begin
        stage[dtlb_idx] <= pwdata;
      end
      if (dtlb_full & ~dtlb_flush) begin
        for (int i = 0; i < 4; i++) begin
          dtlb_word[i] <= stage[i];
        end
      end
      if (dtlb_flush | dtlb_full) begin
        staged <= staged_set;
      end else begin
        staged <= staged | staged_set;
      end
    end
  end

  // read-to-write spacing held between four and nine cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rmw_busy <= 1'b0;
      rmw_cnt <= 5'h0;
      rmw_goal <= `RMW_MIN_CYC;
      rmw_write_ok <= 1'b1;
    end else if (ipr_read_issue) begin
      rmw_busy <= 1'b1;
      rmw_cnt <= 5'h1;
      rmw_goal <= rmw_target(queue_depth);
      rmw_write_ok <= 1'b0;
    end else if (rmw_busy) begin
      // saturate at the goal so a long idle wait cannot wrap and drop the grant
      rmw_cnt <= (rmw_cnt < rmw_goal) ? rmw_cnt + 5'd1 : rmw_cnt;
      rmw_write_ok <= (rmw_cnt >= rmw_goal - 5'd1);
      rmw_busy <= ~ipr_write_issue;
    end else begin
      rmw_write_ok <= 1'b1;
    end
  end

  // trap lock window
  trap_lock_unit u_lock (
    .pclk(pclk),
    .presetn(presetn),
    .trap_valid(trap.valid),
    .retire_valid(retire_valid),
    .retire_taken_branch(retire_taken_branch),
    .accept(accept),
    .trap_to_fw(trap_to_fw),
    .trap_replay(trap_replay),
    .locked(locked)
  );

  // replay slot marking
  replay_mark_unit u_mark (
    .pclk(pclk),
    .presetn(presetn),
    .replay_trap(replay_trap),
    .replay_pc_lo(replay_pc_lo),
    .replay_is_mem(replay_is_mem),
    .enq(enq),
    .mark_valid(mark_valid),
    .mark_pos(mark_pos),
    .skip_dirty(skip_dirty),
    .head_issue(head_issue)
  );
endmodule : ipr_hazard_ctrl

// ### sim/ipr_hazard_ctrl_assertions.sv
`timescale 1ns/10ps
`include "ipr_hazard_map.svh"
module ipr_hazard_ctrl_assertions
  import ipr_hazard_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DEPTH_W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb answer
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // events
  input wire ipr_hazard_pkg::trap_t trap,
  input wire logic retire_valid,
  input wire logic retire_taken_branch,
  input wire logic ipr_write_retire,
  input wire logic replay_trap,
  input wire logic [1:0] replay_pc_lo,
  input wire logic replay_is_mem,
  input wire ipr_hazard_pkg::enq_t enq,
  input wire logic ipr_read_issue,
  input wire logic ipr_write_issue,
  input wire logic [DEPTH_W-1:0] queue_depth,
  input wire logic fetch_valid,
  input wire logic [63:0] fetch_va,
  input wire logic data_valid,
  input wire logic [63:0] data_va,
  // results
  input wire logic trap_to_fw,
  input wire logic trap_replay,
  input wire logic locked,
  input wire logic skip_dirty,
  input wire logic head_issue,
  input wire logic rmw_write_ok,
  input wire logic istream_va48,
  input wire logic dstream_va48,
  input wire logic [15:0] dbl_miss_entry,
  input wire logic istream_access_violation,
  input wire logic dstream_access_violation,
  input wire logic dtlb_commit,
  input wire logic [3:0][31:0] dtlb_word
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // retirements counted while locked
  logic [2:0] rcnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rcnt <= 3'h0;
    else rcnt <= locked ? rcnt + {2'h0, retire_valid} : 3'h0;
  end
  // upper bits must copy the top bit for the width in force
  wire i_bad = istream_va48 ? fetch_va[63:47] != {17{fetch_va[63]}} : fetch_va[63:42] != {22{fetch_va[63]}};
  wire d_bad = dstream_va48 ? data_va[63:47] != {17{data_va[63]}} : data_va[63:42] != {22{data_va[63]}};
  wire unlock = retire_valid && (retire_taken_branch || rcnt == 3'h3);
  // a mode edge skips one compare, the check follows the active copy
  property p_err; pready |-> pslverr == (paddr > 8'h3C || paddr[1:0] != 2'h0); endproperty
  a_err: assert property (p_err) else $error("slave error decode wrong");
  property p_accept; trap.valid && !locked |=> trap_to_fw && locked; endproperty
  a_accept: assert property (p_accept) else $error("trap not taken");
  property p_replay; trap.valid && locked |=> trap_replay && !trap_to_fw; endproperty
  a_replay: assert property (p_replay) else $error("locked trap not replayed");
  property p_hold; locked && !unlock |=> locked; endproperty
  a_hold: assert property (p_hold) else $error("lock dropped early");
  property p_unlock; locked && unlock |=> !locked; endproperty
  a_unlock: assert property (p_unlock) else $error("lock not released");
  property p_head; replay_trap && replay_is_mem |=> head_issue; endproperty
  a_head: assert property (p_head) else $error("replayed op not at head");
  property p_skip; $past(replay_trap) && enq.valid && enq.pos == $past(replay_pc_lo) |=> skip_dirty; endproperty
  a_skip: assert property (p_skip) else $error("dirty check not skipped");
  property p_rmw; ipr_read_issue |=> !rmw_write_ok; endproperty
  a_rmw: assert property (p_rmw) else $error("write allowed right after read");
  property p_rmw9;
    ipr_read_issue && queue_depth >= 4'h5 ##1 (!ipr_read_issue && !ipr_write_issue)[*7] |=> !rmw_write_ok;
  endproperty
  a_rmw9: assert property (p_rmw9) else $error("deep queue gap too short");
  property p_entry; dbl_miss_entry == (istream_va48 ? `DBL4_ENTRY : `DBL3_ENTRY); endproperty
  a_entry: assert property (p_entry) else $error("double miss entry wrong");
  property p_istream_access_violation; 1'b1 |=> $changed(istream_va48) || istream_access_violation == $past(fetch_valid && i_bad); endproperty
  a_istream_access_violation: assert property (p_istream_access_violation) else $error("fetch limit wrong");
  property p_dacv; 1'b1 |=> $changed(dstream_va48) || dstream_access_violation == $past(data_valid && d_bad); endproperty
  a_dacv: assert property (p_dacv) else $error("data limit wrong");
  property p_atomic; $changed(dtlb_word) |-> dtlb_commit; endproperty
  a_atomic: assert property (p_atomic) else $error("tlb words moved without commit");
  property p_mode; $changed({istream_va48, dstream_va48}) |-> $past(ipr_write_retire, 2); endproperty
  a_mode: assert property (p_mode) else $error("mode changed without retire");
  c_trap: cover property (trap_to_fw);
  c_replay: cover property (trap_replay);
  c_skip: cover property (skip_dirty);
  c_commit: cover property (dtlb_commit);
endmodule : ipr_hazard_ctrl_assertions

bind ipr_hazard_ctrl ipr_hazard_ctrl_assertions #(.ADDR_W(ADDR_W), .DEPTH_W(DEPTH_W)) checker_inst (.*);

// ### sim/testbench.sv
`timescale 1ns/10ps
`include "ipr_hazard_map.svh"
module testbench;
  import ipr_hazard_pkg::*;
  // design ports and bench state
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  trap_t trap;
  dfault_t dfault;
  enq_t enq;
  logic retire_valid, retire_taken_branch, ipr_write_retire, replay_trap, replay_is_mem;
  logic [1:0] replay_pc_lo;
  logic ipr_read_issue, ipr_write_issue, fetch_valid, data_valid, dtlb_flush;
  logic [3:0] queue_depth;
  logic [63:0] fetch_va, data_va;
  logic trap_to_fw, trap_replay, locked, skip_dirty, head_issue, rmw_write_ok;
  logic istream_va48, dstream_va48, istream_fmt32, dstream_fmt32, dtlb_commit;
  logic istream_access_violation, dstream_access_violation;
  logic [15:0] dbl_miss_entry;
  logic [3:0][31:0] dtlb_word;
  int err_total, cmp_count, n;
  logic [3:0] dep [2] = '{4'h2, 4'h7};
  int goal [2] = '{6, 9};

  ipr_hazard_ctrl ipr_hazard_ctrl_inst (.*);

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    wrap_up();
  end

  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask : chk

  // outputs are read just after an edge, so they show the sampled value
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    rdv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_mode(input logic [31:0] v);
    apb(1'b1, `OFS_CTRL, v);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rdv[`STAT_PEND], 1);
    @(posedge pclk);
    ipr_write_retire <= 1'b1;
    @(posedge pclk);
    ipr_write_retire <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(istream_va48, v[0]);
    chk(dstream_va48, v[1]);
    chk(istream_fmt32, v[2]);
    chk(dstream_fmt32, v[3]);
    chk(dbl_miss_entry, v[0] ? `DBL4_ENTRY : `DBL3_ENTRY);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rdv, v);
  endtask : set_mode

  task automatic acv(input logic [63:0] va, input logic ei, input logic ed);
    @(posedge pclk);
    fetch_valid <= 1'b1;
    data_valid <= 1'b1;
    fetch_va <= va;
    data_va <= va;
    @(posedge pclk);
    fetch_valid <= 1'b0;
    data_valid <= 1'b0;
    @(posedge pclk);
    chk(istream_access_violation, ei);
    chk(dstream_access_violation, ed);
  endtask : acv

  task automatic fire(input trap_t t);
    @(posedge pclk);
    trap <= t;
    @(posedge pclk);
    trap <= '0;
    @(posedge pclk);
  endtask : fire

  task automatic retire(input logic br);
    @(posedge pclk);
    retire_valid <= 1'b1;
    retire_taken_branch <= br;
    @(posedge pclk);
    retire_valid <= 1'b0;
    retire_taken_branch <= 1'b0;
    @(posedge pclk);
  endtask : retire

  // main sequence
  initial begin
    {psel, penable, pwrite, retire_valid, retire_taken_branch, ipr_write_retire, replay_trap} = '0;
    {replay_is_mem, ipr_read_issue, ipr_write_issue, fetch_valid, data_valid, dtlb_flush} = '0;
    {paddr, pwdata, replay_pc_lo, queue_depth, fetch_va, data_va} = '0;
    trap = '0;
    dfault = '0;
    enq = '0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(rmw_write_ok, 1);
    chk(dbl_miss_entry, `DBL3_ENTRY);
    set_mode(32'h1);
    acv(64'h0000_0400_0000_0000, 1'b0, 1'b1);
    acv(64'h0000_8000_0000_0000, 1'b1, 1'b1);
    acv(64'hFFFF_FFFF_FFFF_F000, 1'b0, 1'b0);
    set_mode(32'h2);
    acv(64'h0000_0400_0000_0000, 1'b1, 1'b0);
    // trap, refused trap, fault while locked
    fire('{1'b1, 64'h0000_0000_1234_5678, 1'b1, 1'b0, 1'b0, 32'h0000_00A5});
    chk(trap_to_fw, 1);
    chk(locked, 1);
    fire('{1'b1, 64'h0000_0000_0000_0ABC, 1'b0, 1'b0, 1'b0, 32'h0000_005A});
    chk(trap_replay, 1);
    chk(trap_to_fw, 0);
    @(posedge pclk);
    dfault <= '{1'b1, 64'h0000_0000_0000_2000, 32'h0000_0033};
    @(posedge pclk);
    dfault <= '0;
    apb(1'b0, `OFS_EXCEPTION_ADDRESS_REG_LO, 32'h0);
    chk(rdv, 32'h1234_5679);
    apb(1'b0, `OFS_EXCEPTION_SUMMARY_REG, 32'h0);
    chk(rdv, 32'h0000_00A5);
    apb(1'b0, `OFS_IVA_FMT_LO, 32'h0);
    chk(rdv, 32'h0004_8D10);
    apb(1'b0, `OFS_FAULT_VA_LO, 32'h0);
    chk(rdv, 32'h0000_2000);
    apb(1'b0, `OFS_MEMORY_MGMT_STATUS_REG, 32'h0);
    chk(rdv, 32'h0000_0033);
    apb(1'b0, `OFS_DVA_FMT_LO, 32'h0);
    chk(rdv, 32'h0000_0008);
    repeat (3) retire(1'b0);
    chk(locked, 1);
    retire(1'b0);
    chk(locked, 0);
    // bad jump target after unlock
    fire('{1'b1, 64'h0000_0000_0000_4447, 1'b1, 1'b1, 1'b1, 32'h0});
    chk(trap_to_fw, 1);
    apb(1'b0, `OFS_EXCEPTION_ADDRESS_REG_LO, 32'h0);
    chk(rdv, 32'h1);
    apb(1'b0, `OFS_FAULT_VA_LO, 32'h0);
    chk(rdv, 32'h0000_4446);
    retire(1'b1);
    chk(locked, 0);
    // replay mark, then the matching enqueue
    @(posedge pclk);
    replay_trap <= 1'b1;
    replay_pc_lo <= 2'h2;
    replay_is_mem <= 1'b1;
    enq <= '{1'b1, 2'h1};
    @(posedge pclk);
    replay_trap <= 1'b0;
    enq <= '{1'b1, 2'h2};
    @(posedge pclk);
    enq <= '0;
    chk(head_issue, 1);
    chk(skip_dirty, 0);
    @(posedge pclk);
    chk(skip_dirty, 1);
    // read to write spacing follows queue depth
    foreach (dep[i]) begin
      @(posedge pclk);
      ipr_read_issue <= 1'b1;
      queue_depth <= dep[i];
      @(posedge pclk);
      ipr_read_issue <= 1'b0;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (rmw_write_ok !== 1'b1 && n < 12);
      chk(n, goal[i]);
    end
    // partial tlb set is flushed, a full set commits at once
    for (int i = 0; i < 3; i++) apb(1'b1, `OFS_DTLB_BASE + 8'(4 * i), 32'hD0D0_0000 + i);
    @(posedge pclk);
    dtlb_flush <= 1'b1;
    @(posedge pclk);
    dtlb_flush <= 1'b0;
    apb(1'b1, `OFS_DTLB_LAST, 32'hD0D0_0003);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rdv[8:5], 4'h8);
    chk(dtlb_word[0], 32'h0);
    for (int i = 0; i < 3; i++) apb(1'b1, `OFS_DTLB_BASE + 8'(4 * i), 32'hD0D0_0000 + i);
    repeat (2) @(posedge pclk);
    chk(dtlb_commit, 1);
    for (int i = 0; i < 4; i++) chk(dtlb_word[i], 32'hD0D0_0000 + i);
    // both width bits and both 32-bit format bits set together
    set_mode(32'hF);
    // unmapped and unaligned places
    apb(1'b0, 8'h40, 32'h0);
    chk(se, 1);
    chk(rdv, 32'h0);
    apb(1'b1, 8'h05, 32'h0);
    chk(se, 1);
    wrap_up();
  end
endmodule : testbench
